// ===== hdl/dtc_pkg.sv
package dtc_pkg;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [15:0] DTC_ADDR_LEVEL = 16'hff20;
   localparam logic [15:0] DTC_ADDR_ENABLE = 16'hff22;
   localparam logic [15:0] DTC_ADDR_FLAGS = 16'hff26;
   localparam logic [15:0] DTC_ADDR_CTRL = 16'hff40;
   localparam logic [15:0] DTC_ADDR_COUNT = 16'hff41;
   localparam logic [15:0] DTC_ADDR_IRQ_STAT = 16'hff50;
   localparam logic [15:0] DTC_ADDR_IRQ_CLR = 16'hff51;
   localparam logic [15:0] DTC_ADDR_IRQ_EN = 16'hff52;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int DTC_CTRL_RUN_BIT = 0;
   localparam int DTC_CTRL_CLR_BIT = 1;
   localparam int DTC_CNT_32HZ_BIT = 2;
   localparam int DTC_CNT_8HZ_BIT = 4;
   localparam int DTC_CNT_2HZ_BIT = 6;
   localparam int DTC_CNT_1HZ_BIT = 7;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] DTC_COUNT_RST = 8'h00;
   localparam logic [1:0] DTC_LEVEL_RST = 2'h0;
   localparam logic [3:0] DTC_SRC_RST = 4'h0;

   // ---------------------------------------------------------------
   // Vectors, per source 1, 2, 8, 32 Hz (index 0..3)
   // ---------------------------------------------------------------
   localparam logic [23:0] DTC_VEC_32HZ = 24'h000034;
   localparam logic [23:0] DTC_VEC_8HZ = 24'h000036;
   localparam logic [23:0] DTC_VEC_2HZ = 24'h000038;
   localparam logic [23:0] DTC_VEC_1HZ = 24'h00003a;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int DTC_CLK_HZ = 100000000;
   localparam int DTC_TICK_HZ = 256;
   localparam int DTC_HALF_TICK_CYC = DTC_CLK_HZ / (2 * DTC_TICK_HZ);

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } dtc_bus_req_t;

   typedef struct packed {
      logic [7:0] count;
      logic tick_phase;
      logic [17:0] div_cnt;
      logic run;
      logic run_req;
      logic [1:0] level;
      logic [3:0] enable;
      logic [3:0] flags;
      logic [1:0] tick_stat;
      logic [1:0] tick_en;
      logic [7:0] rdata;
   } dtc_state_t;
endpackage

// ===== hdl/dtc_top.sv
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ns
// What this block does
// (RULE1) Eight-bit counter increments on each 256 Hz tick from the slow clock; here the tick is divided down from clk_sys_i.
// (RULE2) Counter bit 0 reads as 128 Hz, bit 7 as 1 Hz.
// (RULE3) Writes to the count register are ignored; counter resets to zero.
// (RULE4) Writing one to the clear bit zeroes the count; running continues.
// (RULE5) The clear bit always reads zero.
// (RULE6) Run bit one counts up, zero holds the count for later resumption.
// (RULE7) Run bit resets to stopped and reads back its value.
// (RULE8) Run changes take effect only at the next 256 Hz falling edge.
// (RULE9) After stop request counter steps once more; run reads one until halted.
// (RULE10) Flags set on falling edges of 32, 8, 2 and 1 Hz bits.
// (RULE11) Flags set whatever the enables or priority say.
// (RULE12) Interrupt requested when flag and enable set and level beats CPU mask.
// (RULE13) Writing one clears a flag, zero leaves it; all clear at reset.
// (RULE14) Four readable enable bits for the 1, 2, 8, 32 Hz sources.
// (RULE15) Two-bit priority field gives level 0 to 3, resets to zero.
// (RULE16) Each source has its own ascending even vector address.
// (RULE17) Software clears the flag and lowers mask before next interrupt.
// (RULE18) Software stops the counter before entering sleep.
// (RULE19) Counter wraps from all ones to zero without an extra event.
module dtc_top
   import dtc_pkg::*;
#(
   parameter int HALF_TICK_CYC = DTC_HALF_TICK_CYC
)
(
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic [15:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [1:0] cpu_mask_i,
   output logic [7:0] rdata_o,
   output logic cpu_irq_o,
   output logic [1:0] cpu_irq_level_o,
   output logic [23:0] cpu_irq_vector_o,
   output logic irq_o
);
   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   logic [1:0] rst_sync;
   logic rst_n;

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   dtc_state_t st;
   dtc_state_t next_st;
   dtc_bus_req_t req;
   logic fall_256;
   logic [3:0] src_fall;
   logic [3:0] pending;

   function automatic logic [3:0] dtc_src_bits(input logic [7:0] c);
      dtc_src_bits = {c[DTC_CNT_32HZ_BIT], c[DTC_CNT_8HZ_BIT], c[DTC_CNT_2HZ_BIT], c[DTC_CNT_1HZ_BIT]};
   endfunction

   assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
   assign fall_256 = st.tick_phase && (st.div_cnt == 18'(HALF_TICK_CYC - 1));
   assign pending = st.flags & st.enable;

   always_comb begin
      logic [7:0] cnt_after;
      cnt_after = st.count;
      next_st = st;
      src_fall = 4'h0;
      // Free-running 256 Hz divider, toggles phase every half period
      if (st.div_cnt == 18'(HALF_TICK_CYC - 1)) begin
         next_st.div_cnt = 18'h0;
         next_st.tick_phase = !st.tick_phase;
      end else begin
         next_st.div_cnt = st.div_cnt + 18'h1;
      end
      // Count on the tick falling edge, wrap is silent
      if (fall_256) begin
         if (st.run) begin
            cnt_after = st.count + 8'h1; // RULE1 RULE19
         end
         next_st.run = st.run_req; // RULE8 RULE9
      end
      // Bit goes 1 -> 0 on this step
      src_fall = dtc_src_bits(st.count) & ~dtc_src_bits(cnt_after); // RULE10
      if (req.wr && req.addr == DTC_ADDR_CTRL) begin
         next_st.run_req = req.wdata[DTC_CTRL_RUN_BIT]; // RULE6
         if (req.wdata[DTC_CTRL_CLR_BIT]) begin
            cnt_after = DTC_COUNT_RST; // RULE4
         end
      end
      next_st.count = cnt_after;
      // Flags: set wins over clear
      if (req.wr && req.addr == DTC_ADDR_FLAGS) begin
         next_st.flags = st.flags & ~req.wdata[3:0]; // RULE13
      end
      next_st.flags = next_st.flags | src_fall; // RULE11
      if (req.wr && req.addr == DTC_ADDR_ENABLE) begin
         next_st.enable = req.wdata[3:0]; // RULE14
      end
      if (req.wr && req.addr == DTC_ADDR_LEVEL) begin
         next_st.level = req.wdata[1:0]; // RULE15
      end
      // Block-level events: bit0 counter step, bit1 any source flag
      if (req.wr && req.addr == DTC_ADDR_IRQ_CLR) begin
         next_st.tick_stat = st.tick_stat & ~req.wdata[1:0];
      end
      next_st.tick_stat = next_st.tick_stat | {(src_fall != 4'h0), (fall_256 && st.run)};
      if (req.wr && req.addr == DTC_ADDR_IRQ_EN) begin
         next_st.tick_en = req.wdata[1:0];
      end
      // Read data, one cycle later; count register ignores writes
      next_st.rdata = 8'h00;
      if (req.rd) begin
         unique case (req.addr)
            DTC_ADDR_LEVEL: next_st.rdata = {6'h0, st.level};
            DTC_ADDR_ENABLE: next_st.rdata = {4'h0, st.enable};
            DTC_ADDR_FLAGS: next_st.rdata = {4'h0, st.flags};
            DTC_ADDR_CTRL: next_st.rdata = {7'h0, st.run}; // RULE5 RULE7
            DTC_ADDR_COUNT: next_st.rdata = st.count; // RULE2 RULE3
            DTC_ADDR_IRQ_STAT: next_st.rdata = {6'h0, st.tick_stat};
            DTC_ADDR_IRQ_EN: next_st.rdata = {6'h0, st.tick_en};
            default: next_st.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         st <= '{count: DTC_COUNT_RST, tick_phase: 1'b0, div_cnt: 18'h0, run: 1'b0, run_req: 1'b0,
                 level: DTC_LEVEL_RST, enable: DTC_SRC_RST, flags: DTC_SRC_RST, tick_stat: 2'h0,
                 tick_en: 2'h0, rdata: 8'h00}; // RULE3 RULE7
      end else begin
         st <= next_st;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   always_comb begin
      cpu_irq_vector_o = DTC_VEC_1HZ;
      if (pending[3]) begin
         cpu_irq_vector_o = DTC_VEC_32HZ; // RULE16
      end else if (pending[2]) begin
         cpu_irq_vector_o = DTC_VEC_8HZ;
      end else if (pending[1]) begin
         cpu_irq_vector_o = DTC_VEC_2HZ;
      end
   end

   assign cpu_irq_o = (pending != 4'h0) && (st.level > cpu_mask_i); // RULE12
   assign cpu_irq_level_o = st.level;
   assign irq_o = (st.tick_stat & st.tick_en) != 2'h0;
   assign rdata_o = st.rdata;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_read_ignores_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE3
      (wr_i && addr_i == DTC_ADDR_COUNT && !fall_256) |=> st.count == $past(st.count))
      else $error("count changed by a write");
   a_clear_zeroes: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE4
      (wr_i && addr_i == DTC_ADDR_CTRL && wdata_i[DTC_CTRL_CLR_BIT]) |=> st.count == 8'h00)
      else $error("clear strobe did not zero count");
   a_clear_reads_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE5
      (rd_i && addr_i == DTC_ADDR_CTRL) |=> rdata_o[DTC_CTRL_CLR_BIT] == 1'b0)
      else $error("clear bit read as one");
   a_stopped_holds: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE6
      (!st.run && !(wr_i && addr_i == DTC_ADDR_CTRL)) |=> st.count == $past(st.count))
      else $error("stopped counter moved");
   a_run_on_edge: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE8
      (st.run != $past(st.run)) |-> $past(fall_256))
      else $error("run changed off tick edge");
   a_count_step: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE1
      (fall_256 && st.run && !wr_i) |=> st.count == $past(st.count) + 8'h1)
      else $error("counter did not step on tick");
   a_flag_sets: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE10
      (src_fall[0]) |=> st.flags[0])
      else $error("1 Hz flag missed its edge");
   a_flag_w1c: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE13
      (wr_i && addr_i == DTC_ADDR_FLAGS && wdata_i[1] && !src_fall[1]) |=> !st.flags[1])
      else $error("flag not cleared by one");
   a_irq_level: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE12
      (st.level == 2'h0) |-> !cpu_irq_o)
      else $error("irq raised at level zero");

   // ---------------------------------------------------------------
   // Register reads
   // ---------------------------------------------------------------
   a_count_readback: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE2
      (rd_i && addr_i == DTC_ADDR_COUNT) |=> rdata_o == $past(st.count))
      else $error("count read back wrong");
   a_run_readback: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE7
      (rd_i && addr_i == DTC_ADDR_CTRL) |=> rdata_o == {7'h0, $past(st.run)})
      else $error("run bit read back wrong");
   a_ctrl_upper_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE7
      (rd_i && addr_i == DTC_ADDR_CTRL) |=> rdata_o[7:1] == 7'h0)
      else $error("control upper bits not zero");
   a_level_readback: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE15
      (rd_i && addr_i == DTC_ADDR_LEVEL) |=> rdata_o == {6'h0, $past(st.level)})
      else $error("level read back wrong");
   a_enable_readback: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE14
      (rd_i && addr_i == DTC_ADDR_ENABLE) |=> rdata_o == {4'h0, $past(st.enable)})
      else $error("enables read back wrong");
   a_flags_readback: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE13
      (rd_i && addr_i == DTC_ADDR_FLAGS) |=> rdata_o == {4'h0, $past(st.flags)})
      else $error("flags read back wrong");
   a_stat_readback: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (rd_i && addr_i == DTC_ADDR_IRQ_STAT) |=> rdata_o == {6'h0, $past(st.tick_stat)})
      else $error("status read back wrong");
   a_clr_reads_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (rd_i && addr_i == DTC_ADDR_IRQ_CLR) |=> rdata_o == 8'h00)
      else $error("status clear read as nonzero");
   a_rdata_idle: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (!rd_i) |=> rdata_o == 8'h00)
      else $error("read data stands without a read");

   // ---------------------------------------------------------------
   // Register writes
   // ---------------------------------------------------------------
   a_level_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE15
      (wr_i && addr_i == DTC_ADDR_LEVEL) |=> st.level == $past(wdata_i[1:0]))
      else $error("level write lost");
   a_level_keeps: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE15
      (!(wr_i && addr_i == DTC_ADDR_LEVEL)) |=> st.level == $past(st.level))
      else $error("level changed without write");
   a_enable_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE14
      (wr_i && addr_i == DTC_ADDR_ENABLE) |=> st.enable == $past(wdata_i[3:0]))
      else $error("enable write lost");
   a_enable_keeps: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE14
      (!(wr_i && addr_i == DTC_ADDR_ENABLE)) |=> st.enable == $past(st.enable))
      else $error("enables changed without write");
   a_tick_en_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (wr_i && addr_i == DTC_ADDR_IRQ_EN) |=> st.tick_en == $past(wdata_i[1:0]))
      else $error("status enable write lost");
   a_stat_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (wr_i && addr_i == DTC_ADDR_IRQ_CLR && wdata_i[0] && !(fall_256 && st.run)) |=> !st.tick_stat[0])
      else $error("step status not cleared");

   // ---------------------------------------------------------------
   // Run control and counting
   // ---------------------------------------------------------------
   a_run_req_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE6
      (wr_i && addr_i == DTC_ADDR_CTRL) |=> st.run_req == $past(wdata_i[DTC_CTRL_RUN_BIT]))
      else $error("run request not taken");
   a_run_holds: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE8
      (!fall_256) |=> st.run == $past(st.run))
      else $error("run moved between tick edges");
   a_run_applies: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE8
      (fall_256) |=> st.run == $past(st.run_req))
      else $error("run request not applied on edge");
   a_stop_steps: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE9
      (fall_256 && st.run && !st.run_req && !wr_i) |=> (st.count == $past(st.count) + 8'h1) && !st.run)
      else $error("stop did not step once more");
   a_start_no_step: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE8
      (fall_256 && !st.run && st.run_req && !wr_i) |=> (st.count == $past(st.count)) && st.run)
      else $error("start stepped on its own edge");
   a_off_edge_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE1
      (!fall_256 && !(wr_i && addr_i == DTC_ADDR_CTRL)) |=> st.count == $past(st.count))
      else $error("count moved off tick edge");
   a_write_zero_clr: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE4
      (wr_i && addr_i == DTC_ADDR_CTRL && !wdata_i[DTC_CTRL_CLR_BIT] && !fall_256) |=> st.count == $past(st.count))
      else $error("zero clear bit moved count");
   a_wrap_silent: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE19
      (fall_256 && st.run && st.count == 8'hff && !wr_i) |=> st.count == 8'h00)
      else $error("counter did not wrap to zero");
   a_stat_step: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (fall_256 && st.run) |=> st.tick_stat[0])
      else $error("step status missed");

   // ---------------------------------------------------------------
   // Interrupt flags
   // ---------------------------------------------------------------
   a_flag_32_sets: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE10
      (src_fall[3]) |=> st.flags[3])
      else $error("32 Hz flag missed its edge");
   a_flag_8_sets: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE10
      (src_fall[2]) |=> st.flags[2])
      else $error("8 Hz flag missed its edge");
   a_flag_2_sets: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE10
      (src_fall[1]) |=> st.flags[1])
      else $error("2 Hz flag missed its edge");
   a_flag_no_cause: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE10
      (src_fall == 4'h0) |=> (st.flags & ~$past(st.flags)) == 4'h0)
      else $error("flag set without an edge");
   a_flag_ignores_en: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE11
      (src_fall[3] && !st.enable[3]) |=> st.flags[3])
      else $error("disabled 32 Hz flag not set");
   a_flag_1_no_en: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE11
      (src_fall[0] && !st.enable[0]) |=> st.flags[0])
      else $error("disabled 1 Hz flag not set");
   a_flag_sticky: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE13
      (!(wr_i && addr_i == DTC_ADDR_FLAGS)) |=> (st.flags & $past(st.flags)) == $past(st.flags))
      else $error("flag dropped without a clear");
   a_flag_set_wins: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE13
      (wr_i && addr_i == DTC_ADDR_FLAGS && wdata_i[0] && src_fall[0]) |=> st.flags[0])
      else $error("clear beat a same cycle event");
   a_flag_w0_keeps: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE13
      (wr_i && addr_i == DTC_ADDR_FLAGS && !wdata_i[2] && st.flags[2]) |=> st.flags[2])
      else $error("writing zero cleared a flag");

   // ---------------------------------------------------------------
   // Interrupt outputs
   // ---------------------------------------------------------------
   a_irq_no_pending: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE12
      (pending == 4'h0) |-> !cpu_irq_o)
      else $error("irq without an enabled flag");
   a_irq_masked: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE12
      (st.level <= cpu_mask_i) |-> !cpu_irq_o)
      else $error("irq passed the cpu mask");
   a_irq_raised: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE12
      (pending != 4'h0 && st.level > cpu_mask_i) |-> cpu_irq_o)
      else $error("irq missing");
   a_vector_32: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE16
      (pending[3]) |-> cpu_irq_vector_o == DTC_VEC_32HZ)
      else $error("32 Hz vector wrong");
   a_vector_8: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE16
      (pending[3:2] == 2'b01) |-> cpu_irq_vector_o == DTC_VEC_8HZ)
      else $error("8 Hz vector wrong");
   a_vector_2: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE16
      (pending[3:1] == 3'b001) |-> cpu_irq_vector_o == DTC_VEC_2HZ)
      else $error("2 Hz vector wrong");
   a_vector_1: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE16
      (pending[3:1] == 3'b000) |-> cpu_irq_vector_o == DTC_VEC_1HZ)
      else $error("1 Hz vector wrong");

   // ---------------------------------------------------------------
   // Tick divider
   // ---------------------------------------------------------------
   a_phase_toggle: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE1
      (st.div_cnt == 18'(HALF_TICK_CYC - 1)) |=> st.tick_phase != $past(st.tick_phase))
      else $error("tick phase did not toggle");
   a_phase_steady: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE1
      (st.div_cnt != 18'(HALF_TICK_CYC - 1)) |=> st.tick_phase == $past(st.tick_phase))
      else $error("tick phase toggled early");
   a_div_range: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE1
      st.div_cnt <= 18'(HALF_TICK_CYC - 1))
      else $error("divider out of range");
endmodule

// ===== sim/testbench.sv
`timescale 1ns/1ns
module testbench;
   import dtc_pkg::*;
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [15:0] addr_i = 16'h0000;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [1:0] cpu_mask_i = 2'h0;
   logic [7:0] rdata_o;
   logic cpu_irq_o;
   logic [1:0] cpu_irq_level_o;
   logic [23:0] cpu_irq_vector_o;
   logic irq_o;
   int n_mismatch = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [7:0] d;
   logic [7:0] e;
   localparam int TB_HALF = 4;

   dtc_top #(
      .HALF_TICK_CYC(TB_HALF)
   ) dut (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .addr_i(addr_i),
      .wdata_i(wdata_i),
      .wr_i(wr_i),
      .rd_i(rd_i),
      .cpu_mask_i(cpu_mask_i),
      .rdata_o(rdata_o),
      .cpu_irq_o(cpu_irq_o),
      .cpu_irq_level_o(cpu_irq_level_o),
      .cpu_irq_vector_o(cpu_irq_vector_o),
      .irq_o(irq_o)
   );

   // ------------------------------------------------------------
   // Clock, timeout and tasks
   // ------------------------------------------------------------
   initial begin
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   always @(posedge clk_sys_i) begin
      cycles <= cycles + 1;
      if (cycles == 10000) begin
         n_mismatch = n_mismatch + 1;
         close_out();
      end
   end

   task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
      comparisons = comparisons + 1;
      if (seen !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
      @(posedge clk_sys_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= v;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
   endtask

   task automatic rd_reg(input logic [15:0] a, output logic [7:0] v);
      @(posedge clk_sys_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
   endtask

   // Polls the count until it steps, returns the new value
   task automatic wait_step(output logic [7:0] v);
      logic [7:0] first;
      rd_reg(DTC_ADDR_COUNT, first);
      v = first;
      while (v == first) begin
         rd_reg(DTC_ADDR_COUNT, v);
      end
   endtask

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      rd_reg(DTC_ADDR_COUNT, d); check("count reset", d, 8'h00);
      rd_reg(DTC_ADDR_CTRL, d); check("ctrl reset", d, 8'h00);
      rd_reg(DTC_ADDR_LEVEL, d); check("level reset", d, 8'h00);
      rd_reg(DTC_ADDR_ENABLE, d); check("enable reset", d, 8'h00);
      rd_reg(DTC_ADDR_FLAGS, d); check("flags reset", d, 8'h00);
      $display("reset values done");
      wr_reg(DTC_ADDR_COUNT, 8'h55);
      rd_reg(DTC_ADDR_COUNT, d); check("count write", d, 8'h00);
      wr_reg(DTC_ADDR_CTRL, 8'h02);
      rd_reg(DTC_ADDR_COUNT, d); check("clear stopped", d, 8'h00);
      rd_reg(DTC_ADDR_COUNT, d); check("count stopped", d, 8'h00);
      rd_reg(DTC_ADDR_CTRL, d); check("clear reads 0", d, 8'h00);
      wr_reg(DTC_ADDR_FLAGS, 8'h0f);
      rd_reg(DTC_ADDR_FLAGS, d); check("flags w1c", d, 8'h00);
      $display("control done");
      wr_reg(DTC_ADDR_ENABLE, 8'h0a);
      rd_reg(DTC_ADDR_ENABLE, d); check("enable a", d, 8'h0a);
      wr_reg(DTC_ADDR_ENABLE, 8'h05);
      rd_reg(DTC_ADDR_ENABLE, d); check("enable 5", d, 8'h05);
      for (int i = 3; i >= 0; i--) begin
         wr_reg(DTC_ADDR_LEVEL, 8'(i));
         cpu_mask_i <= 2'(3 - i);
         rd_reg(DTC_ADDR_LEVEL, d); check("level", d, 8'(i));
         check("irq level", cpu_irq_level_o, 24'(i));
         check("cpu irq idle", cpu_irq_o, 24'h0);
         check("vector idle", cpu_irq_vector_o, 24'h00003a);
      end
      $display("priority done");
      rd_reg(DTC_ADDR_IRQ_STAT, d); check("status idle", d, 8'h00);
      wr_reg(DTC_ADDR_IRQ_EN, 8'h03);
      rd_reg(DTC_ADDR_IRQ_EN, d); check("irq enable", d, 8'h03);
      wr_reg(DTC_ADDR_IRQ_CLR, 8'h03);
      rd_reg(DTC_ADDR_IRQ_CLR, d); check("irq clear reads 0", d, 8'h00);
      check("irq idle", irq_o, 24'h0);
      rd_reg(16'hff30, d); check("unmapped", d, 8'h00);
      wr_reg(DTC_ADDR_CTRL, 8'h00);
      rd_reg(DTC_ADDR_CTRL, d); check("run off", d, 8'h00);
      $display("status done");
      wr_reg(DTC_ADDR_ENABLE, 8'h00);
      wr_reg(DTC_ADDR_CTRL, 8'h03);
      repeat (40) @(posedge clk_sys_i);
      rd_reg(DTC_ADDR_COUNT, d); check("count runs", 24'(d >= 8'h03 && d <= 8'h06), 24'h1);
      wait_step(d);
      wr_reg(DTC_ADDR_CTRL, 8'h00);
      rd_reg(DTC_ADDR_CTRL, e); check("run reads 1", e, 8'h01);
      repeat (20) @(posedge clk_sys_i);
      rd_reg(DTC_ADDR_CTRL, e); check("run stopped", e, 8'h00);
      rd_reg(DTC_ADDR_COUNT, e); check("one more step", e, 8'(d + 8'h01));
      repeat (40) @(posedge clk_sys_i);
      rd_reg(DTC_ADDR_COUNT, d); check("count held", d, e);
      wr_reg(DTC_ADDR_CTRL, 8'h01);
      repeat (40) @(posedge clk_sys_i);
      rd_reg(DTC_ADDR_COUNT, d); check("count resumed", 24'(d > e), 24'h1);
      wr_reg(DTC_ADDR_CTRL, 8'h03);
      rd_reg(DTC_ADDR_COUNT, d); check("clear running", 24'(d <= 8'h01), 24'h1);
      repeat (2100) @(posedge clk_sys_i);
      rd_reg(DTC_ADDR_COUNT, d); check("count wrapped", 24'(d < 8'h10), 24'h1);
      rd_reg(DTC_ADDR_FLAGS, d); check("all flags set", d, 8'h0f);
      check("irq status", irq_o, 24'h1);
      $display("counting done");
      wr_reg(DTC_ADDR_LEVEL, 8'h02);
      cpu_mask_i <= 2'h1;
      wr_reg(DTC_ADDR_ENABLE, 8'h01);
      @(negedge clk_sys_i);
      check("irq raised", cpu_irq_o, 24'h1);
      check("vector 1hz", cpu_irq_vector_o, 24'h00003a);
      wr_reg(DTC_ADDR_ENABLE, 8'h08);
      @(negedge clk_sys_i);
      check("vector 32hz", cpu_irq_vector_o, 24'h000034);
      @(posedge clk_sys_i);
      cpu_mask_i <= 2'h2;
      @(negedge clk_sys_i);
      check("irq masked", cpu_irq_o, 24'h0);
      wr_reg(DTC_ADDR_CTRL, 8'h00);
      cpu_mask_i <= 2'h1;
      repeat (20) @(posedge clk_sys_i);
      wr_reg(DTC_ADDR_FLAGS, 8'h0f);
      rd_reg(DTC_ADDR_FLAGS, d); check("flags cleared", d, 8'h00);
      check("irq after clear", cpu_irq_o, 24'h0);
      check("vector after clear", cpu_irq_vector_o, 24'h00003a);
      wr_reg(DTC_ADDR_IRQ_CLR, 8'h03);
      @(negedge clk_sys_i);
      check("irq status clear", irq_o, 24'h0);
      $display("interrupt done");
      close_out();
   end
endmodule
